// File: core/clock_reset_sequencer_consts.svh
// constants for the clock and reset sequencer
`ifndef CLOCK_RESET_SEQUENCER_CONSTS_SVH
`define CLOCK_RESET_SEQUENCER_CONSTS_SVH
`define OFS_OSC_CTRL 8'h88
`define OFS_RST_STATUS 8'h90
`define OFS_CORE_CTRL 8'h94
`define OFS_IRQ_STATUS 8'h98
`define OFS_IRQ_MASK 8'h9c
`define FSEL_LSB 4
`define FSEL_MSB 6
`define FSEL_RESET 3'h6
`define FSEL_16MHZ 3'h7
`define OSC_FAST_MHZ 16
`define OSC_SLOW_MHZ 8
`define CLK_MHZ 200
`define RESET_TIME_US 18000
`define PHASE_TICKS_SINGLE 1
`define PHASE_TICKS_DOUBLE 2
`define RESET_VECTOR 11'h000
`define ST_TIMEOUT 1
`define ST_POWERDOWN 0
`define IRQ_POR 0
`define IRQ_LVR 1
`define IRQ_WDOG 2
`define IRQ_READY 3
`define IRQ_W 4
`endif

// File: core/clock_reset_sequencer_pkg.sv
// types for the clock and reset sequencer
package clock_reset_sequencer_pkg;
  typedef enum logic [1:0] {
    SEQ_HOLD = 2'b00,
    SEQ_INIT = 2'b01,
    SEQ_WAIT = 2'b10,
    SEQ_RUN = 2'b11
  } seq_state_t;
  typedef enum logic [1:0] {
    PH_ONE = 2'b00,
    PH_TWO = 2'b01,
    PH_THREE = 2'b10,
    PH_FOUR = 2'b11
  } phase_t;
endpackage

// File: core/phase_generator.sv
// four phase generator for the instruction cycle
`timescale 1ns/1ps
`default_nettype none
`include "clock_reset_sequencer_consts.svh"
module phase_generator #(
  parameter int TICK_W = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic run,
  input wire logic [TICK_W-1:0] tick_div,
  input wire logic double_cycle,
  output logic phase_one,
  output logic phase_two,
  output logic phase_three,
  output logic phase_four,
  output logic phase_end
);
  logic [TICK_W-1:0] tick_ff;
  logic slot_ff;
  clock_reset_sequencer_pkg::phase_t phase_ff;
  // a shorter divide written mid-phase must not wait for a wrap
  wire tick_done = (tick_ff >= tick_div);
  wire slot_last = double_cycle ? slot_ff : 1'b1; // R7
  wire advance = run && tick_done && slot_last;
  assign phase_end = advance;
  always_ff @(posedge clk) begin
    if (reset || !run) begin
      tick_ff <= '0;
      slot_ff <= 1'b0;
      phase_ff <= clock_reset_sequencer_pkg::PH_ONE;
    end else if (tick_done) begin
      tick_ff <= '0;
      slot_ff <= double_cycle ? ~slot_ff : 1'b0;
      if (slot_last) begin
        phase_ff <= clock_reset_sequencer_pkg::phase_t'(phase_ff + 2'h1); // R1 R6
      end
    end else begin
      tick_ff <= tick_ff + {{(TICK_W-1){1'b0}}, 1'b1};
    end
  end
  // one phase high at a time, none while held
  assign phase_one = run && phase_ff == clock_reset_sequencer_pkg::PH_ONE; // R1
  assign phase_two = run && phase_ff == clock_reset_sequencer_pkg::PH_TWO;
  assign phase_three = run && phase_ff == clock_reset_sequencer_pkg::PH_THREE;
  assign phase_four = run && phase_ff == clock_reset_sequencer_pkg::PH_FOUR;
endmodule
`default_nettype wire

// File: core/reset_sync.sv
// two flop synchroniser for reset source levels
`timescale 1ns/1ps
`default_nettype none
module reset_sync #(
  parameter int W = 3
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  always_ff @(posedge clk) begin
    if (reset) begin
      // sources count as asserted until the flops have filled
      meta_ff <= '1;
      sync_ff <= '1;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end
  assign sync_out = sync_ff;
endmodule
`default_nettype wire

// File: core/clock_reset_sequencer.sv
// core clock phase generator and reset sequencer with axi4-lite registers
// Summary of operation
// R1 - four non-overlapping phases form one cycle
// R2 - phase_one increments pc unless loaded
// R3 - phase_four latches fetched word into ir
// R4 - fetch one cycle, execute the next
// R5 - pc change discards prefetch, costs two
// R6 - single mode: four clock periods per cycle
// R7 - double mode: eight periods per cycle
// R8 - oscillator runs at 8 or 16 MHz
// R9 - freq select bits 6..4, reset 110
// R10 - hold execution about 18ms after reset
// R11 - power-on, low-voltage, watchdog each reset
// R12 - reset restores defaults, clears pc
// R13 - execution restarts at address 0000
// R14 - timeout and powerdown flags record cause
// R15 - power-on: settle, init, osc, run
// R16 - watchdog: reset, init, restart osc, run
// R17 - low_voltage_reset threshold sets trip level
// R18 - watchdog reset clears timeout_flag
// R19 - watchdog overflow works without system clock
`timescale 1ns/1ps
`default_nettype none
`include "clock_reset_sequencer_consts.svh"
module clock_reset_sequencer #(
  parameter int PC_W = 11,
  parameter int IW = 16,
  parameter int TICK_W = 8,
  parameter int RESET_TIME_US = `RESET_TIME_US,
  parameter int RESET_CYCLES = RESET_TIME_US * `CLK_MHZ
) (
  input wire logic clk,
  input wire logic reset,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // reset sources, asynchronous levels
  input wire logic power_on_n,
  input wire logic supply_below_lvr,
  input wire logic watchdog_overflow,
  // program memory and core
  output logic [PC_W-1:0] prog_addr,
  input wire logic [IW-1:0] prog_data,
  input wire logic pc_load,
  input wire logic [PC_W-1:0] pc_load_value,
  output logic [IW-1:0] instr_reg,
  output logic instr_valid,
  output logic phase_one,
  output logic phase_two,
  output logic phase_three,
  output logic phase_four,
  output logic core_reset,
  output logic osc_enable,
  output logic osc_fast,
  output logic timeout_flag,
  output logic powerdown_flag,
  output logic irq
);
  localparam int CNT_W = $clog2(RESET_CYCLES + 1);
  localparam int FAST_DIV = `CLK_MHZ / `OSC_FAST_MHZ;
  localparam int SLOW_DIV = `CLK_MHZ / `OSC_SLOW_MHZ;

  // synchronised reset sources
  logic [2:0] src_raw;
  logic [2:0] src_sync;
  assign src_raw = {watchdog_overflow, supply_below_lvr, ~power_on_n};
  reset_sync #(.W(3)) u_sync (
    .clk(clk),
    .reset(reset),
    .async_in(src_raw),
    .sync_out(src_sync)
  );
  // watchdog request is a level from its own oscillator domain
  wire por_req = src_sync[0];
  wire lvr_req = src_sync[1]; // R17
  wire wdog_req = src_sync[2]; // R19
  wire any_req = por_req || lvr_req || wdog_req; // R11

  // registers
  logic [2:0] fsel_ff;
  logic double_ff;
  logic timeout_ff;
  logic powerdown_ff;
  logic [`IRQ_W-1:0] irq_status_ff;
  logic [`IRQ_W-1:0] irq_mask_ff;

  // reset sequence
  clock_reset_sequencer_pkg::seq_state_t state_ff;
  clock_reset_sequencer_pkg::seq_state_t nxt_state;
  logic [CNT_W-1:0] wait_ff;
  wire wait_done = (wait_ff == CNT_W'(RESET_CYCLES - 1));
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      clock_reset_sequencer_pkg::SEQ_HOLD: begin
        if (!any_req) begin
          nxt_state = clock_reset_sequencer_pkg::SEQ_INIT; // R15 R16
        end
      end
      clock_reset_sequencer_pkg::SEQ_INIT: begin
        nxt_state = clock_reset_sequencer_pkg::SEQ_WAIT;
      end
      clock_reset_sequencer_pkg::SEQ_WAIT: begin
        if (wait_done) begin
          nxt_state = clock_reset_sequencer_pkg::SEQ_RUN; // R10
        end
      end
      clock_reset_sequencer_pkg::SEQ_RUN: begin
        nxt_state = clock_reset_sequencer_pkg::SEQ_RUN;
      end
    endcase
    if (any_req) begin
      nxt_state = clock_reset_sequencer_pkg::SEQ_HOLD; // R11
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= clock_reset_sequencer_pkg::SEQ_HOLD;
    end else begin
      state_ff <= nxt_state;
    end
  end
  always_ff @(posedge clk) begin
    if (reset || state_ff != clock_reset_sequencer_pkg::SEQ_WAIT) begin
      wait_ff <= '0;
    end else if (!wait_done) begin
      wait_ff <= wait_ff + CNT_W'(1);
    end
  end
  wire running = state_ff == clock_reset_sequencer_pkg::SEQ_RUN;
  wire in_hold = state_ff == clock_reset_sequencer_pkg::SEQ_HOLD;
  wire in_init = state_ff == clock_reset_sequencer_pkg::SEQ_INIT;
  assign core_reset = !running; // R12
  // oscillator off while held, restarted after init
  assign osc_enable = !in_hold && !in_init; // R15 R16
  assign osc_fast = (fsel_ff == `FSEL_16MHZ); // R8

  // phase generation
  logic phase_end;
  wire [TICK_W-1:0] tick_div = osc_fast ? TICK_W'(FAST_DIV - 1) : TICK_W'(SLOW_DIV - 1);
  phase_generator #(.TICK_W(TICK_W)) u_phase (
    .clk(clk),
    .reset(reset),
    .run(running),
    .tick_div(tick_div),
    .double_cycle(double_ff),
    .phase_one(phase_one),
    .phase_two(phase_two),
    .phase_three(phase_three),
    .phase_four(phase_four),
    .phase_end(phase_end)
  );

  // pipeline: pc, fetch, execute
  logic [PC_W-1:0] pc_ff;
  logic [IW-1:0] ir_ff;
  logic ir_valid_ff;
  logic flush_ff;
  logic p1_seen_ff;
  wire p1_tick = phase_one && !p1_seen_ff;
  wire p4_end = phase_four && phase_end;
  always_ff @(posedge clk) begin
    if (reset || !running) begin
      p1_seen_ff <= 1'b0;
    end else begin
      p1_seen_ff <= phase_one;
    end
  end
  always_ff @(posedge clk) begin
    if (reset || !running) begin
      pc_ff <= PC_W'(`RESET_VECTOR); // R12 R13
      flush_ff <= 1'b0;
    end else if (p1_tick) begin
      if (pc_load && ir_valid_ff) begin
        pc_ff <= pc_load_value; // R2
        flush_ff <= 1'b1; // R5
      end else begin
        pc_ff <= pc_ff + PC_W'(1); // R2
        flush_ff <= 1'b0;
      end
    end
  end
  // fetch address is the pc after the phase_one increment, taken at the end of phase_four
  logic [PC_W-1:0] fetch_addr_ff;
  always_ff @(posedge clk) begin
    if (reset || !running) begin
      fetch_addr_ff <= PC_W'(`RESET_VECTOR); // R13
    end else if (p4_end) begin
      fetch_addr_ff <= pc_ff;
    end
  end
  assign prog_addr = fetch_addr_ff;
  always_ff @(posedge clk) begin
    if (reset || !running) begin
      ir_ff <= '0;
      ir_valid_ff <= 1'b0;
    end else if (p4_end) begin
      ir_ff <= prog_data; // R3 R4
      ir_valid_ff <= !flush_ff; // R5
    end
  end
  assign instr_reg = ir_ff;
  assign instr_valid = ir_valid_ff && running;

  // reset cause flags
  always_ff @(posedge clk) begin
    if (reset) begin
      timeout_ff <= 1'b1;
      powerdown_ff <= 1'b1;
    end else if (por_req) begin
      timeout_ff <= 1'b1; // R14
      powerdown_ff <= 1'b1;
    end else if (wdog_req) begin
      timeout_ff <= 1'b0; // R18
    end
  end
  assign timeout_flag = timeout_ff;
  assign powerdown_flag = powerdown_ff;

  // axi4-lite slave
  logic aw_hold_ff;
  logic w_hold_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic bvalid_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic rresp_err_ff;
  logic bresp_err_ff;
  assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
  assign s_axi_wready = !w_hold_ff && !bvalid_ff;
  wire aw_have = aw_hold_ff || s_axi_awvalid;
  wire w_have = w_hold_ff || s_axi_wvalid;
  wire wr_fire = aw_have && w_have && !bvalid_ff;
  wire [7:0] wr_addr = aw_hold_ff ? awaddr_ff : s_axi_awaddr;
  wire [31:0] wr_data = w_hold_ff ? wdata_ff : s_axi_wdata;
  wire wr_osc = wr_fire && wr_addr == `OFS_OSC_CTRL && s_axi_wstrb[0];
  wire wr_core = wr_fire && wr_addr == `OFS_CORE_CTRL && s_axi_wstrb[0];
  wire wr_ist = wr_fire && wr_addr == `OFS_IRQ_STATUS && s_axi_wstrb[0];
  wire wr_imask = wr_fire && wr_addr == `OFS_IRQ_MASK && s_axi_wstrb[0];
  wire wr_known = wr_addr == `OFS_OSC_CTRL || wr_addr == `OFS_RST_STATUS ||
    wr_addr == `OFS_CORE_CTRL || wr_addr == `OFS_IRQ_STATUS || wr_addr == `OFS_IRQ_MASK;
  always_ff @(posedge clk) begin
    if (reset) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      bvalid_ff <= 1'b0;
      bresp_err_ff <= 1'b0;
    end else if (wr_fire) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      bvalid_ff <= 1'b1;
      bresp_err_ff <= !wr_known;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
      end
      if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_err_ff ? 2'h2 : 2'h0;

  // control registers, defaults restored on any reset source
  always_ff @(posedge clk) begin
    if (reset || in_hold) begin
      fsel_ff <= `FSEL_RESET; // R9 R12
      double_ff <= 1'b0;
    end else begin
      if (wr_osc) begin
        fsel_ff <= wr_data[`FSEL_MSB:`FSEL_LSB]; // R9
      end
      if (wr_core) begin
        double_ff <= wr_data[0]; // R7
      end
    end
  end

  // interrupt status: set wins over write-one-to-clear
  logic [`IRQ_W-1:0] irq_event;
  logic running_d_ff;
  always_ff @(posedge clk) begin
    if (reset) begin
      running_d_ff <= 1'b0;
    end else begin
      running_d_ff <= running;
    end
  end
  assign irq_event = {running && !running_d_ff, wdog_req, lvr_req, por_req};
  wire [`IRQ_W-1:0] irq_clr = wr_ist ? wr_data[`IRQ_W-1:0] : '0;
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_status_ff <= '0;
      irq_mask_ff <= '0;
    end else begin
      irq_status_ff <= (irq_status_ff & ~irq_clr) | irq_event;
      if (wr_imask) begin
        irq_mask_ff <= wr_data[`IRQ_W-1:0];
      end
    end
  end
  assign irq = |(irq_status_ff & irq_mask_ff);

  // read channel
  wire [7:0] rd_addr = s_axi_araddr;
  wire rd_known = rd_addr == `OFS_OSC_CTRL || rd_addr == `OFS_RST_STATUS ||
    rd_addr == `OFS_CORE_CTRL || rd_addr == `OFS_IRQ_STATUS || rd_addr == `OFS_IRQ_MASK;
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (rd_addr == `OFS_OSC_CTRL) begin
      rd_mux[`FSEL_MSB:`FSEL_LSB] = fsel_ff;
    end
    if (rd_addr == `OFS_RST_STATUS) begin
      rd_mux[`ST_TIMEOUT] = timeout_ff; // R14
      rd_mux[`ST_POWERDOWN] = powerdown_ff;
    end
    if (rd_addr == `OFS_CORE_CTRL) begin
      rd_mux[0] = double_ff;
    end
    if (rd_addr == `OFS_IRQ_STATUS) begin
      rd_mux[`IRQ_W-1:0] = irq_status_ff;
    end
    if (rd_addr == `OFS_IRQ_MASK) begin
      rd_mux[`IRQ_W-1:0] = irq_mask_ff;
    end
  end
  assign s_axi_arready = !rvalid_ff;
  always_ff @(posedge clk) begin
    if (reset) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_err_ff <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_mux;
      rresp_err_ff <= !rd_known;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_err_ff ? 2'h2 : 2'h0;
endmodule
`default_nettype wire

// File: testbench/clock_reset_sequencer_monitor.sv
// assertion checker for the clock and reset sequencer
`timescale 1ns/1ps
`default_nettype none
module clock_reset_sequencer_monitor #(
  parameter int PC_W = 11,
  parameter int IW = 16,
  parameter int RESET_CYCLES = 200
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic power_on_n,
  input wire logic supply_below_lvr,
  input wire logic watchdog_overflow,
  input wire logic [PC_W-1:0] prog_addr,
  input wire logic pc_load,
  input wire logic [IW-1:0] instr_reg,
  input wire logic instr_valid,
  input wire logic phase_one,
  input wire logic phase_two,
  input wire logic phase_three,
  input wire logic phase_four,
  input wire logic core_reset,
  input wire logic osc_enable,
  input wire logic timeout_flag,
  input wire logic powerdown_flag
);
  int hold_cnt_ff;
  logic src_any;
  assign src_any = !power_on_n || supply_below_lvr || watchdog_overflow;
  // cycles spent in reset since the last source released
  always_ff @(posedge clk) begin
    hold_cnt_ff <= (reset || src_any) ? 0 : (core_reset ? hold_cnt_ff + 1 : 0);
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_one_phase;
    $onehot0({phase_one, phase_two, phase_three, phase_four});
  endproperty
  a_one_phase: assert property (p_one_phase) else $error("phases overlap");
  property p_phase_order;
    $fell(phase_one) && !core_reset |-> phase_two;
  endproperty
  a_phase_order: assert property (p_phase_order) else $error("phase order broken");
  property p_idle_phases;
    core_reset |-> !(phase_one || phase_two || phase_three || phase_four);
  endproperty
  a_idle_phases: assert property (p_idle_phases) else $error("phase in reset");
  property p_pc_cleared;
    core_reset [*3] |-> prog_addr == '0;
  endproperty
  a_pc_cleared: assert property (p_pc_cleared) else $error("pc not cleared");
  property p_pc_step;
    $changed(prog_addr) && !core_reset |-> phase_one;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc moved off phase one");
  property p_ir_latch;
    !core_reset && $changed(instr_reg) |-> $past(phase_four);
  endproperty
  a_ir_latch: assert property (p_ir_latch) else $error("ir moved off phase four");
  property p_discard;
    $rose(phase_one) && pc_load && instr_valid && !core_reset |-> ##[1:800] !instr_valid;
  endproperty
  a_discard: assert property (p_discard) else $error("prefetch kept after load");
  property p_osc_run;
    !core_reset |-> osc_enable;
  endproperty
  a_osc_run: assert property (p_osc_run) else $error("running without osc");
  property p_hold_time;
    $fell(core_reset) |-> $past(hold_cnt_ff) >= RESET_CYCLES;
  endproperty
  a_hold_time: assert property (p_hold_time) else $error("reset time too short");
  property p_source;
    src_any |-> ##[1:3] core_reset;
  endproperty
  a_source: assert property (p_source) else $error("source ignored");
  property p_wdog_flag;
    $rose(watchdog_overflow) |-> ##[1:4] !timeout_flag;
  endproperty
  a_wdog_flag: assert property (p_wdog_flag) else $error("timeout flag kept");
  property p_por_flags;
    !power_on_n |-> ##[1:4] (timeout_flag && powerdown_flag);
  endproperty
  a_por_flags: assert property (p_por_flags) else $error("power-on flags wrong");
  c_run: cover property ($fell(core_reset));
  c_jump: cover property ($rose(phase_one) && pc_load && instr_valid);
  c_wdog: cover property ($fell(timeout_flag));
endmodule
bind clock_reset_sequencer clock_reset_sequencer_monitor #(
  .PC_W(PC_W), .IW(IW), .RESET_CYCLES(RESET_CYCLES)) monitor (.*);
`default_nettype wire

// File: testbench/clock_reset_sequencer_tb.sv
// self-checking bench for the clock and reset sequencer
`timescale 1ns/1ps
`default_nettype none
module clock_reset_sequencer_tb;
  logic clk, reset, power_on_n, supply_below_lvr, watchdog_overflow, pc_load;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [10:0] prog_addr, pc_load_value;
  logic [15:0] prog_data, instr_reg;
  logic instr_valid, phase_one, phase_two, phase_three, phase_four, hit, inv;
  logic core_reset, osc_enable, osc_fast, timeout_flag, powerdown_flag, irq;
  int fails, compares, n, pa, fa;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;
    logic [1:0] r; logic q;} row_t;
  localparam row_t rows [10] = '{
    '{1'h0, 8'h88, 32'h0, 32'h60, 2'h0, 1'h0},
    '{1'h0, 8'h90, 32'h0, 32'h3, 2'h0, 1'h0},
    '{1'h0, 8'h9c, 32'h0, 32'h0, 2'h0, 1'h0},
    '{1'h1, 8'h9c, 32'h8, 32'h0, 2'h0, 1'h1},
    '{1'h1, 8'h98, 32'hf, 32'h0, 2'h0, 1'h0},
    '{1'h0, 8'h98, 32'h0, 32'h0, 2'h0, 1'h0},
    '{1'h1, 8'h88, 32'hff, 32'h0, 2'h0, 1'h0},
    '{1'h0, 8'h88, 32'h0, 32'h70, 2'h0, 1'h0},
    '{1'h0, 8'ha0, 32'h0, 32'h0, 2'h2, 1'h0},
    '{1'h1, 8'ha0, 32'h1, 32'h0, 2'h2, 1'h0}};
  // program memory word derived from its address
  assign prog_data = {5'h00, prog_addr} + 16'h1000;
  clock_reset_sequencer #(.RESET_TIME_US(1)) dut (.*);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_run();
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (core_reset !== 1'b0);
    chk({21'h0, prog_addr}, 32'h0);
    chk({31'h0, n >= 200}, 32'h1);
  endtask
  task automatic meas(input int exp);
    repeat (2) begin
      while (phase_one !== 1'b0) @(posedge clk);
      while (phase_one !== 1'b1) @(posedge clk);
      pa = prog_addr;
      n = 0;
      while (phase_four !== 1'b1) begin
        @(posedge clk);
        n++;
      end
      while (phase_one !== 1'b1) begin
        fa = prog_addr;
        @(posedge clk);
        n++;
      end
    end
    chk(n, exp);
    chk({21'h0, prog_addr}, pa + 1);
    @(posedge clk);
    chk({16'h0, instr_reg}, fa + 32'h1000);
  endtask
  initial begin
    reset = 1'b1;
    {power_on_n, supply_below_lvr, watchdog_overflow, pc_load, pc_load_value} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    power_on_n <= 1'b1;
    wait_run();
    chk({30'h0, timeout_flag, powerdown_flag}, 32'h3);
    foreach (rows[i]) begin
      if (rows[i].w) begin
        axw(rows[i].a, rows[i].d, rs);
      end else begin
        axr(rows[i].a, rd, rs);
        chk(rd, rows[i].e);
      end
      chk({30'h0, rs}, {30'h0, rows[i].r});
      @(posedge clk);
      chk({31'h0, irq}, {31'h0, rows[i].q});
    end
    chk({31'h0, osc_fast}, 32'h1);
    meas(48);
    axw(8'h94, 32'h1, rs);
    meas(96);
    axw(8'h94, 32'h0, rs);
    // jump requested for the next instruction cycle
    while (phase_four !== 1'b1) @(posedge clk);
    pc_load <= 1'b1;
    pc_load_value <= 11'h123;
    while (phase_two !== 1'b1) @(posedge clk);
    pc_load <= 1'b0;
    hit = 1'b0;
    inv = 1'b0;
    repeat (300) begin
      @(posedge clk);
      if (prog_addr === 11'h123) hit = 1'b1;
      if (instr_valid === 1'b0) inv = 1'b1;
    end
    chk({31'h0, hit}, 32'h1);
    chk({31'h0, inv}, 32'h1);
    chk({31'h0, instr_valid}, 32'h1);
    watchdog_overflow <= 1'b1;
    repeat (6) @(posedge clk);
    chk({27'h0, phase_one, phase_two, phase_three, phase_four, core_reset}, 32'h1);
    chk({21'h0, prog_addr}, 32'h0);
    watchdog_overflow <= 1'b0;
    wait_run();
    chk({30'h0, timeout_flag, powerdown_flag}, 32'h1);
    chk({31'h0, osc_fast}, 32'h0);
    axr(8'h88, rd, rs);
    chk(rd, 32'h60);
    meas(100);
    supply_below_lvr <= 1'b1;
    repeat (6) @(posedge clk);
    chk({30'h0, core_reset, osc_enable}, 32'h2);
    supply_below_lvr <= 1'b0;
    wait_run();
    chk({30'h0, timeout_flag, powerdown_flag}, 32'h1);
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    summarize();
  end
endmodule
`default_nettype wire
